// file: logic/vsh_pkg.sv
// Purpose: Shared constants of the vibration sensor housekeeping block
// Assumes: 16-bit serial frames, 6-bit byte addresses
// Notes: Offsets are byte addresses; word registers sit at even offsets
package vsh_pkg;
	// Frame layout
	localparam int FRAME_BITS = 16;
	localparam int RW_BIT = 15;
	localparam int ADDR_HI = 13;
	localparam int ADDR_LO = 8;
	localparam int CNT_W = 4;

	// Register offsets
	localparam logic [5:0] ADDR_FLASH_WRITE_COUNTER = 6'h00;
	localparam logic [5:0] ADDR_CAPT_ACCEL = 6'h14;
	localparam logic [5:0] ADDR_LOT_LOW = 6'h2A;
	localparam logic [5:0] ADDR_LOT_HIGH = 6'h2C;
	localparam logic [5:0] ADDR_UNIT_ID = 6'h2E;
	localparam logic [5:0] ADDR_MISC = 6'h34;
	localparam logic [5:0] ADDR_SELF_TEST_DELTA = 6'h38;
	localparam logic [5:0] ADDR_DIAG = 6'h3C;
	localparam logic [5:0] ADDR_GLOB = 6'h3E;

	// Field positions
	localparam int GLOB_SELFTEST_BIT = 2;
	localparam int GLOB_CLEAR_BIT = 4;
	localparam int GLOB_CAPTURE_BIT = 11;
	localparam int MISC_ST_BIT = 8;
	localparam int DIAG_READY = 7;
	localparam int DIAG_SELFTEST = 5;
	localparam int DIAG_VIOL = 4;
	localparam int DIAG_SPI = 3;

	// Reset values and masks
	localparam logic [15:0] MISC_RESET = 16'h0003;
	localparam logic [15:0] MISC_WR_MASK = 16'h0103;
	localparam logic [15:0] LOT_LOW_RSVD = 16'hFF00;
	localparam logic [15:0] ZERO16 = 16'h0000;

	// Capture buffer
	localparam int CAPT_DEPTH = 1024;
	localparam int CAPT_AW = 10;

	// Self-test timing and limits
	localparam int CLK_MHZ = 250;
	localparam int ST_SETTLE_NS = 2000;
	localparam int ST_SETTLE_CYC = (ST_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int ST_CNT_W = 12;
	localparam logic signed [15:0] ST_LIMIT_MIN = 16'sh0010;
	localparam logic signed [15:0] ST_LIMIT_MAX = 16'sh2000;
endpackage

// file: logic/vsh_link_if.sv
// Purpose: Carrier between the serial link logic and the register core
// Assumes: rxWord and frameBits are stable while chip select is high
// Notes: txWord is only changed between frames by the core
`timescale 1ns/1ps
interface vsh_link_if;
	import vsh_pkg::*;
	logic [15:0] rxWord;
	logic [CNT_W-1:0] frameBits;
	logic [15:0] txWord;
	modport link (output rxWord, output frameBits, input txWord);
	modport core (input rxWord, input frameBits, output txWord);
endinterface

// file: logic/vsh_spi_link.sv
// Purpose: Serial link front end, runs on the host serial clock
// Assumes: Mode 3 style: sample on rising, shift out on falling edge
// Notes: Chip select high clears the frame marker and output index
`timescale 1ns/1ps
module vsh_spi_link (
	input wire logic rst,
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	output logic miso,
	vsh_link_if.link lnk
);
	import vsh_pkg::*;

	logic [CNT_W-1:0] outIdx;
	logic inFrame;

	////////////////////////////////////////////////////////////////////
	// Input shift; the word holds still after the frame for the core
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			lnk.rxWord <= ZERO16;
		end else if (!csN) begin
			lnk.rxWord <= {lnk.rxWord[14:0], mosi};
		end
	end

	// Marks the first rising edge of a frame; chip select high clears it
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			inFrame <= 1'b0;
		end else begin
			inFrame <= 1'b1;
		end
	end

	// Count restarts on the first edge and survives chip select rising,
	// so the core still sees it when the frame end reaches its clock
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			lnk.frameBits <= '0;
		end else if (!csN && !inFrame) begin
			lnk.frameBits <= CNT_W'(1'b1);
		end else if (!csN) begin
			lnk.frameBits <= lnk.frameBits + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// First falling edge launches the MSB, so only falling edges after
	// a rising edge of this frame move on; txWord is static in a frame
	always_ff @(negedge sclk or posedge csN) begin
		if (csN) begin
			outIdx <= '0;
		end else if (inFrame) begin
			outIdx <= outIdx + 1'b1;
		end
	end

	// Previous frame's answer goes out MSB first
	assign miso = lnk.txWord[~outIdx];
endmodule

// file: logic/vsh_selftest_hk.sv
// Purpose: Self-test, identification, flash counter and capture control
// Assumes: Host is the serial master; samples arrive on clk strobes
// Notes: Answers to a read appear in the next frame
// Summary of operation
// - Global command bit 2 runs an automatic self-test, flags failure.
// - Self-test delta holds the 16-bit signed output change.
// - Misc control bit 8 excites the element, clears itself when done.
// - Manual capture during excitation records the excited response.
// - Misc control bits 1..0 enable supply compensation; reset 0x0003.
// - Lot code is 24 bits: low byte in lot low [15:8], rest high.
// - Per-unit identifier is a read-only 16-bit number.
// - Flash write counter adds one per flash write.
// - After supply is good, start up in manual capture mode.
// - Writing global command bit 11 starts a manual capture.
// - Repeated reads of 0x14 return samples one frame late.
// - Serial traffic during a capture sets the violation flag.
// - Error flags read 1, hold until next capture or clear command.
`timescale 1ns/1ps
module vsh_selftest_hk (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	output logic miso,
	input wire logic powerGood,
	input wire logic [15:0] accelSample,
	input wire logic sampleStrobe,
	input wire logic flashWriteDone,
	input wire logic [23:0] lotCode,
	input wire logic [15:0] unitSerial,
	output logic stExcite,
	output logic busy,
	output logic manualCaptureMode,
	output logic [1:0] supplyCompEn
);
	import vsh_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_BASE = 5'b00010,
		ST_SETTLE = 5'b00100,
		ST_EXCITED = 5'b01000,
		ST_JUDGE = 5'b10000
	} vsh_st_t;

	vsh_link_if lnk ();
	logic [2:0] csSync;
	logic frameEnd;
	logic [1:0] pgSync;
	logic [15:0] miscControl;
	logic [15:0] selfTestDelta;
	logic [15:0] flashWriteCounter;
	logic [15:0] diagnosticFlags;
	logic [15:0] captureMem [CAPT_DEPTH];
	logic [CAPT_AW-1:0] captPtr;
	logic [CAPT_AW-1:0] readPtr;
	logic capturing;
	vsh_st_t stState;
	logic [ST_CNT_W-1:0] stTimer;
	logic signed [15:0] baseSample;
	logic signed [15:0] next_delta;
	logic frameOk;
	logic isWrite;
	logic [5:0] frameAddr;
	logic [7:0] frameData;
	logic wrGlobHi;
	logic wrGlobLo;
	logic wrMiscHi;
	logic wrMiscLo;
	logic startCapture;
	logic startSelfTest;
	logic clearFlags;
	logic captureLast;

	vsh_spi_link u_link (
		.rst(rst),
		.sclk(sclk),
		.csN(csN),
		.mosi(mosi),
		.miso(miso),
		.lnk(lnk.link)
	);

	// Register read mux, shared by the answer path
	function automatic logic [15:0] readReg(input logic [5:0] a,
		input logic [15:0] captWord);
		logic [5:0] w;
		w = {a[5:1], 1'b0};
		if (w == ADDR_FLASH_WRITE_COUNTER) begin
			readReg = flashWriteCounter;
		end else if (w == ADDR_CAPT_ACCEL) begin
			readReg = captWord;
		end else if (w == ADDR_LOT_LOW) begin
			readReg = {lotCode[7:0], 8'h00} & LOT_LOW_RSVD;
		end else if (w == ADDR_LOT_HIGH) begin
			readReg = lotCode[23:8];
		end else if (w == ADDR_UNIT_ID) begin
			readReg = unitSerial;
		end else if (w == ADDR_MISC) begin
			readReg = miscControl;
		end else if (w == ADDR_SELF_TEST_DELTA) begin
			readReg = selfTestDelta;
		end else if (w == ADDR_DIAG) begin
			readReg = diagnosticFlags;
		end else begin
			readReg = ZERO16;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Chip select and supply level cross into clk; stage one is never read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csSync <= 3'h7;
			pgSync <= 2'h0;
		end else begin
			csSync <= {csSync[1:0], csN};
			pgSync <= {pgSync[0], powerGood};
		end
	end

	// Rising chip select ends a frame; link data is frozen by then
	assign frameEnd = csSync[1] && !csSync[2];
	assign frameOk = (lnk.frameBits == '0);
	assign isWrite = lnk.rxWord[RW_BIT];
	assign frameAddr = lnk.rxWord[ADDR_HI:ADDR_LO];
	assign frameData = lnk.rxWord[7:0];

	////////////////////////////////////////////////////////////////////
	// Frame decode; traffic during a capture is not acted upon
	always_comb begin
		wrGlobHi = 1'b0;
		wrGlobLo = 1'b0;
		wrMiscHi = 1'b0;
		wrMiscLo = 1'b0;
		if (frameEnd && frameOk && isWrite && !busy) begin
			if (frameAddr == (ADDR_GLOB | 6'h01)) begin
				wrGlobHi = 1'b1;
			end else if (frameAddr == ADDR_GLOB) begin
				wrGlobLo = 1'b1;
			end else if (frameAddr == (ADDR_MISC | 6'h01)) begin
				wrMiscHi = 1'b1;
			end else if (frameAddr == ADDR_MISC) begin
				wrMiscLo = 1'b1;
			end
		end
	end

	// Command bits act as one-cycle strobes, never stored
	assign startCapture = manualCaptureMode && wrGlobHi &&
		frameData[GLOB_CAPTURE_BIT-8];
	assign startSelfTest = wrGlobLo && frameData[GLOB_SELFTEST_BIT];
	assign clearFlags = wrGlobLo && frameData[GLOB_CLEAR_BIT];
	assign captureLast = capturing && sampleStrobe &&
		(captPtr == CAPT_AW'(CAPT_DEPTH - 1));

	////////////////////////////////////////////////////////////////////
	// Start-up: manual capture mode once the supply is seen good
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			manualCaptureMode <= 1'b0;
		end else if (pgSync[1]) begin
			manualCaptureMode <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Misc control; bit 8 self-clears when the capture it feeds is done
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			miscControl <= MISC_RESET;
		end else if (wrMiscLo) begin
			miscControl[7:0] <= frameData & MISC_WR_MASK[7:0];
		end else if (wrMiscHi) begin
			miscControl[15:8] <= frameData & MISC_WR_MASK[15:8];
		end else if (captureLast) begin
			miscControl[MISC_ST_BIT] <= 1'b0;
		end
	end

	assign supplyCompEn = miscControl[1:0];
	assign stExcite = miscControl[MISC_ST_BIT] || (stState == ST_SETTLE)
		|| (stState == ST_EXCITED);
	assign busy = capturing || (stState != ST_IDLE);

	////////////////////////////////////////////////////////////////////
	// Capture fill; excitation stays on across it so samples show it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			capturing <= 1'b0;
			captPtr <= '0;
		end else if (startCapture) begin
			capturing <= 1'b1;
			captPtr <= '0;
		end else if (capturing && sampleStrobe) begin
			captPtr <= captPtr + 1'b1;
			if (captureLast) begin
				capturing <= 1'b0;
			end
		end
	end
	// Buffer array has no reset; its content is only valid after capture
	always_ff @(posedge clk) begin
		if (capturing && sampleStrobe) begin
			captureMem[captPtr] <= accelSample;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read pointer steps per buffer read; answer loads for next frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readPtr <= '0;
			lnk.txWord <= ZERO16;
		end else if (startCapture) begin
			readPtr <= '0;
			lnk.txWord <= ZERO16;
		end else if (frameEnd && frameOk && !isWrite && !busy) begin
			lnk.txWord <= readReg(frameAddr, captureMem[readPtr]);
			if ({frameAddr[5:1], 1'b0} == ADDR_CAPT_ACCEL) begin
				readPtr <= readPtr + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Automatic self-test: baseline, excite, settle, sample, judge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stState <= ST_IDLE;
			stTimer <= '0;
			baseSample <= '0;
		end else begin
			case (stState)
				ST_IDLE: begin
					if (startSelfTest) begin
						stState <= ST_BASE;
					end
				end
				ST_BASE: begin
					if (sampleStrobe) begin
						baseSample <= accelSample;
						stTimer <= '0;
						stState <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					stTimer <= stTimer + 1'b1;
					if (stTimer == ST_CNT_W'(ST_SETTLE_CYC - 1)) begin
						stState <= ST_EXCITED;
					end
				end
				ST_EXCITED: begin
					if (sampleStrobe) begin
						stState <= ST_JUDGE;
					end
				end
				ST_JUDGE: begin
					stState <= ST_IDLE;
				end
				default: begin
					stState <= ST_IDLE;
				end
			endcase
		end
	end

	// Difference wraps in 16 bits, as the delta register is 16 bits
	assign next_delta = 16'(signed'(accelSample) - baseSample);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			selfTestDelta <= ZERO16;
		end else if (stState == ST_EXCITED && sampleStrobe) begin
			selfTestDelta <= next_delta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Diagnostic flags: set wins over capture start or clear command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			diagnosticFlags <= ZERO16;
		end else begin
			if (startCapture || clearFlags) begin
				diagnosticFlags <= ZERO16;
			end
			if (captureLast) begin
				diagnosticFlags[DIAG_READY] <= 1'b1;
			end
			if (stState == ST_JUDGE && (signed'(selfTestDelta) < ST_LIMIT_MIN
				|| signed'(selfTestDelta) > ST_LIMIT_MAX)) begin
				diagnosticFlags[DIAG_SELFTEST] <= 1'b1;
			end
			if (frameEnd && capturing) begin
				diagnosticFlags[DIAG_VIOL] <= 1'b1;
			end
			if (frameEnd && !frameOk) begin
				diagnosticFlags[DIAG_SPI] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks on the clk domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_excited_sample;
		stState == ST_EXCITED && sampleStrobe;
	endsequence
	sequence s_judged;
		stState == ST_JUDGE;
	endsequence
	a_selftest_start: assert property (startSelfTest && stState == ST_IDLE
		|=> stState == ST_BASE)
		else $error("self-test did not start");
	a_selftest_flag: assert property (s_excited_sample ##1 s_judged
		##1 (selfTestDelta < ST_LIMIT_MIN || selfTestDelta > ST_LIMIT_MAX)
		|-> diagnosticFlags[DIAG_SELFTEST])
		else $error("self-test failure not flagged");
	a_delta_capture: assert property (s_excited_sample
		|=> selfTestDelta == $past(next_delta))
		else $error("delta register not loaded");
	a_excite_clear: assert property (captureLast && !wrMiscHi
		|=> !miscControl[MISC_ST_BIT])
		else $error("excitation bit not cleared");
	a_excite_hold: assert property (miscControl[MISC_ST_BIT] && capturing
		&& !captureLast |=> miscControl[MISC_ST_BIT])
		else $error("excitation dropped during capture");
	a_comp_out: assert property (supplyCompEn == miscControl[1:0]
		&& miscControl[15:9] == '0 && miscControl[7:2] == '0)
		else $error("compensation or reserved bits wrong");
	a_startup_mode: assert property ($rose(pgSync[1])
		|=> manualCaptureMode)
		else $error("manual capture mode not entered");
	a_capture_go: assert property (startCapture
		|=> capturing && captPtr == '0)
		else $error("capture did not start");
	a_violation: assert property (frameEnd && capturing
		|=> diagnosticFlags[DIAG_VIOL])
		else $error("violation not flagged");
	a_spi_err: assert property (frameEnd && !frameOk
		|=> diagnosticFlags[DIAG_SPI])
		else $error("frame length error not flagged");
	a_flag_hold: assert property (diagnosticFlags[DIAG_SPI]
		&& !startCapture && !clearFlags |=> diagnosticFlags[DIAG_SPI])
		else $error("error flag lost");
	a_read_step: assert property (frameEnd && frameOk && !isWrite && !busy
		&& {frameAddr[5:1], 1'b0} == ADDR_CAPT_ACCEL && !startCapture
		|=> readPtr == $past(readPtr) + 1'b1)
		else $error("buffer read pointer did not step");
	////////////////////////////////////////////////////////////////////
	// Flash write counter; wraps at 16 bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flashWriteCounter <= ZERO16;
		end else if (flashWriteDone) begin
			flashWriteCounter <= flashWriteCounter + 1'b1;
		end
	end
	a_flash_count: assert property (flashWriteDone
		|=> flashWriteCounter == $past(flashWriteCounter) + 1'b1)
		else $error("flash counter did not step");
endmodule

// file: verification/vsh_host_model.sv
// Purpose: Host serial master model for the housekeeping block
// Assumes: Clock idles high, device samples data on rising edges
// Notes: Serial clock stands still between frames
`timescale 1ns/1ps
module vsh_host_model (
	output logic sclk,
	output logic csN,
	output logic mosi,
	input wire logic miso
);
	localparam int HALF = 3;

	////////////////////////////////////////////////////////////////////////
	// Idle levels from time zero
	initial begin
		sclk = 1'b1;
		csN = 1'b1;
		mosi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One frame, word MSB first; short counts only to provoke an error
	task automatic xfer(input logic [15:0] word, input int nBits,
		output logic [15:0] reply);
		reply = 16'h0000;
		csN = 1'b0;
		#(HALF);
		for (int i = 0; i < nBits; i++) begin
			sclk = 1'b0;
			mosi = word[15 - i];
			#(HALF);
			sclk = 1'b1;
			reply = {reply[14:0], miso};
			#(HALF);
		end
		csN = 1'b1;
		// Released line must not keep showing the last bit
		mosi = ~mosi;
		// Gap well above the three core cycles a frame end needs
		#40;
	endtask
endmodule

// file: verification/vsh_selftest_hk_bench.sv
// Purpose: Self-checking bench for the housekeeping block
// Assumes: Host model drives the serial link at a 6 ns clock
// Notes: Buffer readback is the longest part of the run
`timescale 1ns/1ps
module vsh_selftest_hk_bench;
	import vsh_pkg::*;
	localparam logic [23:0] LOT = 24'hA5C317;
	localparam logic [15:0] UNIT = 16'h5E21;
	localparam int LIMIT = 80000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic powerGood = 1'b0;
	logic [15:0] accelSample = 16'h0000;
	logic sampleStrobe = 1'b0;
	logic flashWriteDone = 1'b0;
	logic sclk, csN, mosi, miso, stExcite, busy, manualCaptureMode;
	logic [1:0] supplyCompEn;
	logic [15:0] rdata;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Device and host
	vsh_selftest_hk vsh_selftest_hk_i (.clk(clk), .rst(rst), .sclk(sclk),
		.csN(csN), .mosi(mosi), .miso(miso), .powerGood(powerGood),
		.accelSample(accelSample), .sampleStrobe(sampleStrobe),
		.flashWriteDone(flashWriteDone), .lotCode(LOT),
		.unitSerial(UNIT), .stExcite(stExcite), .busy(busy),
		.manualCaptureMode(manualCaptureMode),
		.supplyCompEn(supplyCompEn));
	vsh_host_model vsh_host_model_i (.sclk(sclk), .csN(csN), .mosi(mosi),
		.miso(miso));

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] word);
		vsh_host_model_i.xfer(word, 16, rdata);
	endtask
	// Reply to a read arrives in the following frame
	task automatic rd(input logic [5:0] addr, output logic [15:0] val);
		vsh_host_model_i.xfer({2'b00, addr, 8'h00}, 16, rdata);
		vsh_host_model_i.xfer(16'h0000, 16, val);
	endtask
	task automatic strobe(input logic [15:0] val);
		tick(1);
		accelSample = val;
		sampleStrobe = 1'b1;
		tick(1);
		sampleStrobe = 1'b0;
	endtask
	// Bounded wait; host must not talk while busy
	task automatic wait_idle();
		for (int i = 0; i < 4000 && busy !== 1'b0; i++)
			tick(1);
		check("busy", {15'h0, busy}, 16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_reset();
		check("compEn", {14'h0, supplyCompEn}, 16'h0003);
		check("mode before", {15'h0, manualCaptureMode}, 16'h0000);
		powerGood = 1'b1;
		tick(5);
		check("mode", {15'h0, manualCaptureMode}, 16'h0001);
		rd(ADDR_MISC, rdata);
		check("misc reset", rdata, 16'h0003);
	endtask
	task automatic test_ids();
		rd(ADDR_LOT_LOW, rdata);
		check("lot low", rdata, {LOT[7:0], 8'h00});
		rd(ADDR_LOT_HIGH, rdata);
		check("lot high", rdata, LOT[23:8]);
		wr(16'hAE55);
		rd(ADDR_UNIT_ID, rdata);
		check("unit id", rdata, UNIT);
		rd(6'h02, rdata);
		check("unmapped", rdata, 16'h0000);
	endtask
	task automatic test_flash();
		rd(ADDR_FLASH_WRITE_COUNTER, rdata);
		check("flash base", rdata, 16'h0000);
		repeat (3) begin
			tick(1);
			flashWriteDone = 1'b1;
			tick(1);
			flashWriteDone = 1'b0;
		end
		rd(ADDR_FLASH_WRITE_COUNTER, rdata);
		check("flash count", rdata, 16'h0003);
	endtask
	task automatic test_misc();
		wr(16'hB4FC);
		check("compEn off", {14'h0, supplyCompEn}, 16'h0000);
		wr(16'hB5FF);
		check("excite", {15'h0, stExcite}, 16'h0001);
		rd(ADDR_MISC, rdata);
		check("misc", rdata, 16'h0100);
	endtask
	// Excited capture, one violating frame, then full readback
	task automatic test_capture();
		wr(16'hBF08);
		check("busy run", {15'h0, busy}, 16'h0001);
		vsh_host_model_i.xfer(16'h3C00, 16, rdata);
		for (int i = 0; i < 1024; i++)
			strobe(16'h4000 + 16'(i * 7));
		wait_idle();
		check("excite end", {15'h0, stExcite}, 16'h0000);
		rd(ADDR_MISC, rdata);
		check("misc end", rdata, 16'h0000);
		rd(ADDR_DIAG, rdata);
		check("diag capt", rdata, 16'h0090);
		vsh_host_model_i.xfer(16'h1400, 16, rdata);
		for (int i = 0; i <= 1024; i++) begin
			vsh_host_model_i.xfer(16'h1400, 16, rdata);
			check("sample", rdata, 16'h4000 + 16'((i % 1024) * 7));
		end
	endtask
	task automatic clear_flags();
		wr(16'hBE10);
		rd(ADDR_DIAG, rdata);
		check("diag clear", rdata, 16'h0000);
	endtask
	task automatic test_frame();
		clear_flags();
		vsh_host_model_i.xfer(16'h3C00, 15, rdata);
		rd(ADDR_DIAG, rdata);
		check("diag frame", rdata, 16'h0008);
		clear_flags();
	endtask
	// Automatic self-test with a given baseline and change
	task automatic st_run(input logic [15:0] base, input logic [15:0] d,
		input logic [15:0] expDiag);
		wr(16'hBE04);
		strobe(base);
		tick(300);
		check("st excite", {15'h0, stExcite}, 16'h0001);
		tick(300);
		strobe(base + d);
		wait_idle();
		rd(ADDR_SELF_TEST_DELTA, rdata);
		check("delta", rdata, d);
		rd(ADDR_DIAG, rdata);
		check("diag st", rdata, expDiag);
		clear_flags();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tick(5);
		rst = 1'b0;
		tick(2);
		test_reset();
		test_ids();
		test_flash();
		test_misc();
		test_capture();
		test_frame();
		st_run(16'h0100, 16'h0010, 16'h0000);
		st_run(16'hFFF0, 16'h2000, 16'h0000);
		st_run(16'h0100, 16'h2001, 16'h0020);
		st_run(16'hFFF0, 16'h000F, 16'h0020);
		finish_test();
	end
endmodule
